// ===== verilog/cnvm_cfg.svh
// addresses, field positions and constants of the nonvolatile save/load controller
`ifndef CNVM_CFG_SVH
`define CNVM_CFG_SVH

`define CNVM_ADDR_W        12
`define CNVM_DATA_W        8
`define CNVM_NVM_AW        10
`define CNVM_SEG_AW        8
`define CNVM_SEG_DEPTH     256
`define CNVM_CNT_W         7

`define CNVM_REG_STATUS    12'hb00
`define CNVM_REG_DERR      12'hb01
`define CNVM_REG_CTRL      12'hb02
`define CNVM_REG_SAVE      12'hb03
`define CNVM_SEG_PAGE      4'ha

`define CNVM_BIT_BUSY      0
`define CNVM_BIT_DERR      0
`define CNVM_BIT_WREN      0
`define CNVM_BIT_SOFT      1
`define CNVM_BIT_SAVE      0
`define CNVM_BIT_OPCODE    7

`define CNVM_OP_IO_UPDATE  8'h80
`define CNVM_OP_END        8'hff
`define CNVM_NVM_LAST      10'h3ff
`define CNVM_ZERO_BYTE     8'h00
`define CNVM_ZERO_CNT      7'h00

`endif

// ===== verilog/cnvm_pkg.sv
// state and phase types of the nonvolatile save/load controller
package cnvm_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SRST,
    ST_FETCH,
    ST_WAIT,
    ST_PUT,
    ST_DONE
  } cnvm_state_e;

  typedef enum logic [1:0] {
    PH_CMD,
    PH_AHI,
    PH_ALO,
    PH_DATA
  } cnvm_phase_e;

endpackage

// ===== verilog/cnvm_seg_mem.sv
// buffer segment storage, one write port, one registered read port
`include "cnvm_cfg.svh"

module cnvm_seg_mem
(
  input  wire logic                      sys_clk,
  input  wire logic                      ce,
  input  wire logic                      wr_en,
  input  wire logic [`CNVM_SEG_AW-1:0]   wr_addr,
  input  wire logic [`CNVM_DATA_W-1:0]   wr_data,
  input  wire logic [`CNVM_SEG_AW-1:0]   rd_addr,
  output logic      [`CNVM_DATA_W-1:0]   rd_data
);

  logic [`CNVM_DATA_W-1:0] mem [`CNVM_SEG_DEPTH];

  always_ff @(posedge sys_clk)
  begin
    if (ce && wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // no reset on the array, contents come from software
  always_ff @(posedge sys_clk)
  begin
    if (ce)
    begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule // cnvm_seg_mem

// ===== verilog/cnvm_ctrl.sv
// save/load controller between the register buffer bank and nonvolatile memory
//
// Notes on behaviour
// - busy flag reads 1 during any transfer
// - busy flag drives status pin when routed
// - data error flag reports bad transferred data
// - soft reset reloads stored settings only while load_sel_n is low, self-clearing
// - write enable resets 0, blocks saves
// - save bit starts copy, clears when done
// - command bit7 clear: count-1, address follows
// - bit7 set: update or end opcode
`include "cnvm_cfg.svh"

module cnvm_ctrl
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      ce,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  input  wire logic [`CNVM_ADDR_W-1:0]   reg_addr,
  input  wire logic [`CNVM_DATA_W-1:0]   reg_wdata,
  output logic      [`CNVM_DATA_W-1:0]   reg_rdata,
  input  wire logic                      load_sel_n,
  input  wire logic                      status_route_en,
  output logic                           status_pin,
  output logic                           soft_rst,
  output logic                           io_update,
  output logic                           cfg_rd,
  output logic      [`CNVM_ADDR_W-1:0]   cfg_addr,
  input  wire logic [`CNVM_DATA_W-1:0]   cfg_rdata,
  output logic                           cfg_wr,
  output logic      [`CNVM_DATA_W-1:0]   cfg_wdata,
  output logic                           nvm_req,
  output logic                           nvm_we,
  output logic      [`CNVM_NVM_AW-1:0]   nvm_addr,
  output logic      [`CNVM_DATA_W-1:0]   nvm_wdata,
  input  wire logic                      nvm_ack,
  input  wire logic [`CNVM_DATA_W-1:0]   nvm_rdata,
  input  wire logic                      nvm_err
);

  // ****************************************
  // pin synchroniser and register port
  // ****************************************
  cnvm_pkg::cnvm_state_e st;
  cnvm_pkg::cnvm_phase_e ph;
  logic                      sel_s1;
  logic                      sel_s2;
  logic                      wr_enable;
  logic                      data_err;
  logic                      is_save;
  logic                      busy;
  logic                      start_save;
  logic                      start_load;
  logic                      seg_hit_q;
  logic                      go;
  logic                      seg_ptr_en;
  logic [`CNVM_DATA_W-1:0]   rdata_q;
  logic [`CNVM_DATA_W-1:0]   seg_q;
  logic [`CNVM_DATA_W-1:0]   byte_q;
  logic [`CNVM_SEG_AW-1:0]   seg_ptr;
  logic [`CNVM_SEG_AW-1:0]   seg_raddr;
  logic [`CNVM_NVM_AW-1:0]   nvm_ptr;
  logic [`CNVM_CNT_W-1:0]    cnt;
  logic [15:0]               xfer_addr;
  logic                      seg_wr;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
    end
    else if (ce)
    begin
      sel_s1 <= load_sel_n;
      sel_s2 <= sel_s1;
    end
  end

  assign busy = (st != cnvm_pkg::ST_IDLE);
  // a new request while busy is dropped, not queued
  assign start_load = reg_wr && (reg_addr == `CNVM_REG_CTRL) && reg_wdata[`CNVM_BIT_SOFT]
                      && !sel_s2 && !busy;
  assign start_save = reg_wr && (reg_addr == `CNVM_REG_SAVE) && reg_wdata[`CNVM_BIT_SAVE]
                      && wr_enable && !busy;
  assign seg_wr = reg_wr && (reg_addr[`CNVM_ADDR_W-1:`CNVM_SEG_AW] == `CNVM_SEG_PAGE);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wr_enable <= 1'b0;
    end
    else if (ce && reg_wr && (reg_addr == `CNVM_REG_CTRL))
    begin
      wr_enable <= reg_wdata[`CNVM_BIT_WREN];
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q   <= `CNVM_ZERO_BYTE;
      seg_hit_q <= 1'b0;
    end
    else if (ce && reg_rd)
    begin
      seg_hit_q <= (reg_addr[`CNVM_ADDR_W-1:`CNVM_SEG_AW] == `CNVM_SEG_PAGE);
      rdata_q   <= `CNVM_ZERO_BYTE;
      case (reg_addr)
        `CNVM_REG_STATUS: rdata_q[`CNVM_BIT_BUSY] <= busy;
        `CNVM_REG_DERR:   rdata_q[`CNVM_BIT_DERR] <= data_err;
        `CNVM_REG_CTRL:
        begin
          rdata_q[`CNVM_BIT_WREN] <= wr_enable;
          rdata_q[`CNVM_BIT_SOFT] <= busy && !is_save;
        end
        `CNVM_REG_SAVE:   rdata_q[`CNVM_BIT_SAVE] <= busy && is_save;
        default:          rdata_q <= `CNVM_ZERO_BYTE;
      endcase
    end
  end

  assign reg_rdata = seg_hit_q ? seg_q : rdata_q;

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      status_pin <= 1'b0;
    end
    else if (ce)
    begin
      status_pin <= status_route_en && busy;
    end
  end

  // ****************************************
  // buffer segment
  // ****************************************
  // the walk owns the read port while busy; bus reads of the segment then return the byte at seg_ptr
  assign seg_raddr = busy ? seg_ptr : reg_addr[`CNVM_SEG_AW-1:0];

  cnvm_seg_mem u_seg
  (
    .sys_clk (sys_clk),
    .ce      (ce),
    .wr_en   (seg_wr),
    .wr_addr (reg_addr[`CNVM_SEG_AW-1:0]),
    .wr_data (reg_wdata),
    .rd_addr (seg_raddr),
    .rd_data (seg_q)
  );

  // ****************************************
  // transfer walk
  // ****************************************
  assign go         = (st == cnvm_pkg::ST_PUT) && (!is_save || nvm_ack);
  assign seg_ptr_en = (st == cnvm_pkg::ST_FETCH) && is_save && (ph != cnvm_pkg::PH_DATA);
  assign cfg_rd     = (st == cnvm_pkg::ST_FETCH) && is_save && (ph == cnvm_pkg::PH_DATA);
  assign nvm_req    = ((st == cnvm_pkg::ST_FETCH) && !is_save)
                      || ((st == cnvm_pkg::ST_PUT) && is_save);
  assign nvm_we     = is_save && (st == cnvm_pkg::ST_PUT);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st      <= cnvm_pkg::ST_IDLE;
      is_save <= 1'b0;
    end
    else if (ce)
    begin
      case (st)
        cnvm_pkg::ST_IDLE:
        begin
          if (start_save)
          begin
            is_save <= 1'b1;
            st      <= cnvm_pkg::ST_FETCH;
          end
          else if (start_load)
          begin
            is_save <= 1'b0;
            st      <= cnvm_pkg::ST_SRST;
          end
        end
        cnvm_pkg::ST_SRST:  st <= cnvm_pkg::ST_FETCH;
        cnvm_pkg::ST_FETCH:
        begin
          if (is_save || nvm_ack)
          begin
            st <= is_save ? cnvm_pkg::ST_WAIT : cnvm_pkg::ST_PUT;
          end
        end
        cnvm_pkg::ST_WAIT:  st <= cnvm_pkg::ST_PUT;
        cnvm_pkg::ST_PUT:
        begin
          if (go)
          begin
            // end opcode or a full memory finishes the walk
            if (((ph == cnvm_pkg::PH_CMD) && (byte_q == `CNVM_OP_END))
                || (nvm_ptr == `CNVM_NVM_LAST))
            begin
              st <= cnvm_pkg::ST_DONE;
            end
            else
            begin
              st <= cnvm_pkg::ST_FETCH;
            end
          end
        end
        cnvm_pkg::ST_DONE:  st <= cnvm_pkg::ST_IDLE;
        default:            st <= cnvm_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      byte_q <= `CNVM_ZERO_BYTE;
    end
    else if (ce)
    begin
      if (st == cnvm_pkg::ST_WAIT)
      begin
        byte_q <= (ph == cnvm_pkg::PH_DATA) ? cfg_rdata : seg_q;
      end
      else if ((st == cnvm_pkg::ST_FETCH) && !is_save && nvm_ack)
      begin
        byte_q <= nvm_rdata;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ph        <= cnvm_pkg::PH_CMD;
      cnt       <= `CNVM_ZERO_CNT;
      xfer_addr <= 16'h0000;
    end
    else if (ce && (st == cnvm_pkg::ST_IDLE))
    begin
      ph <= cnvm_pkg::PH_CMD;
    end
    else if (ce && go)
    begin
      case (ph)
        cnvm_pkg::PH_CMD:
        begin
          if (!byte_q[`CNVM_BIT_OPCODE])
          begin
            cnt <= byte_q[`CNVM_CNT_W-1:0];
            ph  <= cnvm_pkg::PH_AHI;
          end
        end
        cnvm_pkg::PH_AHI:
        begin
          xfer_addr[15:8] <= byte_q;
          ph              <= cnvm_pkg::PH_ALO;
        end
        cnvm_pkg::PH_ALO:
        begin
          xfer_addr[7:0] <= byte_q;
          ph             <= cnvm_pkg::PH_DATA;
        end
        cnvm_pkg::PH_DATA:
        begin
          xfer_addr <= xfer_addr + 16'h0001;
          if (cnt == `CNVM_ZERO_CNT)
          begin
            ph <= cnvm_pkg::PH_CMD;
          end
          else
          begin
            cnt <= cnt - 7'h01;
          end
        end
        default: ph <= cnvm_pkg::PH_CMD;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      seg_ptr <= 8'h00;
      nvm_ptr <= 10'h000;
    end
    else if (ce)
    begin
      if (st == cnvm_pkg::ST_IDLE)
      begin
        seg_ptr <= 8'h00;
        nvm_ptr <= 10'h000;
      end
      else
      begin
        if (seg_ptr_en)
        begin
          seg_ptr <= seg_ptr + 8'h01;
        end
        if (nvm_req && nvm_ack)
        begin
          nvm_ptr <= nvm_ptr + 10'h001;
        end
      end
    end
  end

  // outgoing strobes and data
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      soft_rst  <= 1'b0;
      io_update <= 1'b0;
      cfg_wr    <= 1'b0;
      cfg_wdata <= `CNVM_ZERO_BYTE;
      cfg_addr  <= 12'h000;
      nvm_addr  <= 10'h000;
      nvm_wdata <= `CNVM_ZERO_BYTE;
      data_err  <= 1'b0;
    end
    else if (ce)
    begin
      soft_rst  <= start_load;
      io_update <= go && !is_save && (ph == cnvm_pkg::PH_CMD)
                   && (byte_q == `CNVM_OP_IO_UPDATE);
      cfg_wr    <= go && !is_save && (ph == cnvm_pkg::PH_DATA);
      cfg_wdata <= byte_q;
      // address leads the walk so a save read in the fetch cycle sees the right byte
      if (go && (ph == cnvm_pkg::PH_ALO))
      begin
        cfg_addr <= {xfer_addr[`CNVM_ADDR_W-1:`CNVM_DATA_W], byte_q};
      end
      else if (go && (ph == cnvm_pkg::PH_DATA))
      begin
        cfg_addr <= is_save ? (xfer_addr[`CNVM_ADDR_W-1:0] + 12'h001)
                            : xfer_addr[`CNVM_ADDR_W-1:0];
      end
      nvm_addr  <= nvm_ptr;
      // write data settles with byte_q so it stands from the first request cycle
      if (st == cnvm_pkg::ST_WAIT)
      begin
        nvm_wdata <= (ph == cnvm_pkg::PH_DATA) ? cfg_rdata : seg_q;
      end
      if (nvm_req && nvm_ack && nvm_err)
      begin
        data_err <= 1'b1;
      end
      else if (start_save || start_load)
      begin
        data_err <= 1'b0;
      end
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  a_busy_readback: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && reg_rd && (reg_addr == `CNVM_REG_STATUS)) |=> (reg_rdata == {7'h00, $past(busy)}))
    else $error("busy flag read back wrong");

  a_status_pin_route: assert property (@(posedge sys_clk) disable iff (rst)
    ce |=> (status_pin == $past(status_route_en && busy)))
    else $error("status pin does not follow routed busy");

  a_err_readback: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && reg_rd && (reg_addr == `CNVM_REG_DERR)) |=> (reg_rdata[0] == $past(data_err)))
    else $error("data error flag read back wrong");

  a_soft_reload: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && start_load) |=> (soft_rst && (st == cnvm_pkg::ST_SRST)) ##1 !soft_rst)
    else $error("soft reload did not pulse reset and start");

  a_wp_refuse: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && !busy && !wr_enable) |=> !(busy && is_save))
    else $error("save started under write protection");

  a_save_clears: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && (st == cnvm_pkg::ST_DONE) && is_save) |=> !busy)
    else $error("save bit not cleared after copy");

  a_cmd_count: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && go && (ph == cnvm_pkg::PH_CMD) && !byte_q[7])
    |=> ((cnt == $past(byte_q[6:0])) && (ph == cnvm_pkg::PH_AHI)))
    else $error("command byte count or phase wrong");

  a_end_opcode: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && go && (ph == cnvm_pkg::PH_CMD) && (byte_q == `CNVM_OP_END))
    |=> (st == cnvm_pkg::ST_DONE) ##1 !busy)
    else $error("end opcode did not finish transfer");

  a_busy_ignore: assert property (@(posedge sys_clk) disable iff (rst)
    (ce && busy && (st != cnvm_pkg::ST_DONE)) |=> ($stable(is_save) && busy))
    else $error("request disturbed running transfer");

endmodule // cnvm_ctrl

// ===== sim/cnvm_nvm_model.sv
// nonvolatile array model answering the controller's byte requests
module cnvm_nvm_model
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       slow,
  input  wire logic       err_on,
  input  wire logic [9:0] err_addr,
  input  wire logic       nvm_req,
  input  wire logic       nvm_we,
  input  wire logic [9:0] nvm_addr,
  input  wire logic [7:0] nvm_wdata,
  output logic            nvm_ack,
  output logic      [7:0] nvm_rdata,
  output logic            nvm_err
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [1024];
  logic [1:0] cnt;
  int         writes;

  // read data and error toggle between answers, never hold a stale value
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt       <= 2'h0;
      nvm_ack   <= 1'b0;
      nvm_rdata <= 8'h00;
      nvm_err   <= 1'b0;
      writes    <= 0;
    end
    else
    begin
      nvm_ack   <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
      nvm_err   <= ~nvm_err;
      cnt       <= nvm_req ? cnt + 2'h1 : 2'h0;
      if (nvm_req && !nvm_ack && cnt >= {slow, 1'b0})
      begin
        nvm_ack   <= 1'b1;
        cnt       <= 2'h0;
        nvm_err   <= err_on && nvm_addr == err_addr;
        nvm_rdata <= mem[nvm_addr];
        if (nvm_we)
        begin
          mem[nvm_addr] <= nvm_wdata;
          writes        <= writes + 1;
        end
      end
    end
  end
endmodule // cnvm_nvm_model

// ===== sim/cnvm_ctrl_test.sv
// self-checking bench of the save/load controller
`include "cnvm_cfg.svh"

module cnvm_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk, rst, reg_wr, reg_rd, load_sel_n, status_route_en, slow, err_on;
  logic        status_pin, soft_rst, io_update, cfg_rd, cfg_wr, nvm_req, nvm_we, nvm_ack;
  logic        nvm_err, ce;
  logic [11:0] reg_addr, cfg_addr;
  logic [7:0]  reg_wdata, reg_rdata, cfg_rdata, cfg_wdata, nvm_wdata, nvm_rdata, rd;
  logic [9:0]  nvm_addr, err_addr;
  logic [7:0]  cfg_space [4096];
  logic [7:0]  seg [5] = '{8'h01, 8'h00, 8'h10, 8'h80, 8'hff};
  logic [7:0]  img [7] = '{8'h01, 8'h00, 8'h10, 8'h4a, 8'h4b, 8'h80, 8'hff};
  int          fail_count = 0, comparisons = 0, cycles = 0;
  int          soft_n = 0, upd_n = 0, pin_n = 0, p0;

  cnvm_ctrl cnvm_ctrl_i (.sys_clk, .rst, .ce, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .load_sel_n, .status_route_en, .status_pin, .soft_rst, .io_update, .cfg_rd,
    .cfg_addr, .cfg_rdata, .cfg_wr, .cfg_wdata, .nvm_req, .nvm_we, .nvm_addr, .nvm_wdata,
    .nvm_ack, .nvm_rdata, .nvm_err);

  cnvm_nvm_model cnvm_nvm_model_i (.sys_clk, .rst, .slow, .err_on, .err_addr, .nvm_req,
    .nvm_we, .nvm_addr, .nvm_wdata, .nvm_ack, .nvm_rdata, .nvm_err);

  // ********************
  // clock, register space, monitors
  // ********************
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // register space answers one cycle after cfg_rd, scrambled otherwise
  initial cfg_rdata = 8'h00;
  always @(posedge sys_clk)
  begin
    cycles    <= cycles + 1;
    cfg_rdata <= cfg_rd ? (cfg_addr[7:0] ^ 8'h5a) : ~cfg_rdata;
    if (cfg_wr)
      cfg_space[cfg_addr] <= cfg_wdata;
    if (soft_rst)
      soft_n <= soft_n + 1;
    if (io_update)
      upd_n <= upd_n + 1;
    if (status_pin)
      pin_n <= pin_n + 1;
    if (cycles == 10000)
    begin
      fail_count++;
      final_report();
    end
  end

  // ********************
  // tasks
  // ********************
  task automatic final_report;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic rdv(input logic [11:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    d      = reg_rdata;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp, input string what);
    rdv(a, rd);
    chk(rd, exp, what);
  endtask

  task automatic wait_idle;
    int n;
    n  = 0;
    rd = 8'hff;
    while (rd !== 8'h00 && n < 300)
    begin
      rdv(`CNVM_REG_STATUS, rd);
      n++;
    end
    chk(rd, 8'h00, "transfer never finished");
  endtask

  // ********************
  // main sequence
  // ********************
  initial
  begin
    rst             = 1'b1;
    ce              = 1'b1;
    reg_wr          = 1'b0;
    reg_rd          = 1'b0;
    reg_addr        = 12'h000;
    reg_wdata       = 8'h00;
    load_sel_n      = 1'b1;
    status_route_en = 1'b1;
    slow            = 1'b0;
    err_on          = 1'b0;
    err_addr        = 10'h004;
    repeat (6) @(negedge sys_clk);
    rst = 1'b0;
    rdc(12'hb00, 8'h00, "busy at reset");
    rdc(12'hb01, 8'h00, "error at reset");
    rdc(12'hb02, 8'h00, "control at reset");
    rdc(12'hb03, 8'h00, "save bit at reset");
    rdc(12'hb04, 8'h00, "unmapped read");
    // segment: two bytes from 0x010, update code, end code
    foreach (seg[i])
      wr(12'ha00 | 12'(i), seg[i]);
    rdc(12'ha03, 8'h80, "segment readback");
    wr(12'hb03, 8'h01);
    repeat (4) @(negedge sys_clk);
    rdc(12'hb00, 8'h00, "save started while protected");
    chk(8'(cnvm_nvm_model_i.writes), 8'h00, "memory written while protected");
    wr(12'hb02, 8'h01);
    rdc(12'hb02, 8'h01, "write enable readback");
    slow = 1'b1;
    wr(12'hb03, 8'h01);
    rdc(12'hb00, 8'h01, "busy during save");
    rdc(12'hb03, 8'h01, "save bit while running");
    chk(8'(status_pin), 8'h01, "status pin during save");
    load_sel_n = 1'b0;
    // let the pin pass its synchroniser so only busy can refuse the reload
    repeat (2) @(negedge sys_clk);
    wr(12'hb02, 8'h03);
    wr(12'hb03, 8'h01);
    wait_idle();
    load_sel_n = 1'b1;
    chk(8'(soft_n), 8'h00, "soft reset taken mid-save");
    chk(8'(cnvm_nvm_model_i.writes), 8'h07, "save byte count");
    foreach (img[i])
      chk(cnvm_nvm_model_i.mem[i], img[i], "stored image");
    rdc(12'hb03, 8'h00, "save bit after save");
    rdc(12'hb01, 8'h00, "error after clean save");
    repeat (1000) @(negedge sys_clk);
    // reload with pin unrouted and a corrupted data byte
    status_route_en = 1'b0;
    err_on          = 1'b1;
    slow            = 1'b0;
    load_sel_n      = 1'b0;
    p0              = pin_n;
    repeat (3) @(negedge sys_clk);
    wr(12'hb02, 8'h03);
    rdc(12'hb02, 8'h03, "soft bit while loading");
    wait_idle();
    chk(8'(soft_n), 8'h01, "one soft reset");
    chk(8'(upd_n), 8'h01, "one update");
    chk(cfg_space[12'h010], 8'h4a, "reloaded byte 0");
    chk(cfg_space[12'h011], 8'h4b, "reloaded byte 1");
    chk(8'(pin_n - p0), 8'h00, "status pin while unrouted");
    rdv(12'hb02, rd);
    chk(rd & 8'h02, 8'h00, "soft bit after load");
    rdc(12'hb01, 8'h01, "error after bad byte");
    load_sel_n = 1'b1;
    repeat (1000) @(negedge sys_clk);
    wr(12'hb02, 8'h03);
    repeat (6) @(negedge sys_clk);
    chk(8'(soft_n), 8'h01, "soft reset with pin high");
    // a frozen block must not take a write
    ce = 1'b0;
    wr(12'hb02, 8'h00);
    ce = 1'b1;
    rdc(12'hb02, 8'h01, "write taken with clock enable low");
    err_on = 1'b0;
    wr(12'hb03, 8'h01);
    wait_idle();
    rdc(12'hb01, 8'h00, "error cleared by new transfer");
    final_report();
  end
endmodule // cnvm_ctrl_test
